// file: core/ipr_map.vh
// Purpose: Register offsets, field layout and reset values for the priority resolver
// Assumes: Wishbone classic slave with 32-bit data, one register per aligned word
// Notes:   Only definitions live here
`ifndef IPR_MAP_VH
`define IPR_MAP_VH

// Register byte offsets
`define IPR_OFS_FLAG0     8'h00
`define IPR_OFS_FLAG1     8'h04
`define IPR_OFS_FLAG2     8'h08
`define IPR_OFS_ENA0      8'h0C
`define IPR_OFS_ENA1      8'h10
`define IPR_OFS_ENA2      8'h14
`define IPR_OFS_CPUPL     8'h18
`define IPR_OFS_WIN       8'h1C
`define IPR_OFS_RSTCAUSE  8'h20
`define IPR_OFS_PRIO_BASE 8'h40
`define IPR_PRIO_REGS     14

// Priority nibble layout
`define IPR_NIB_W        4
`define IPR_PRIO_W       3
`define IPR_PRIO_MASK    16'h7777

// Vector numbering
`define IPR_VEC_BASE     6'h08

// Sources that exist; all others are reserved and never request
`define IPR_IMPL_MASK    54'h00_07E1_E87F_7FEF

// Reset cause bit positions
`define IPR_RC_WDT       0
`define IPR_RC_UNINIT_W  1
`define IPR_RC_ILLEGAL   2
`define IPR_RC_LOCKOUT   3
`define IPR_RC_EXT       4

// Reset values
`define IPR_RST_WORD     16'h0000
`define IPR_RST_PC       24'h00_0000

`endif

// file: core/ipr_prio_mem.v
// Purpose: Small register file holding the per-source priority nibbles
// Assumes: One write port, one registered read port, full parallel view for arbitration
// Notes:   Bit 3 of every nibble is never stored and reads as zero
`timescale 1ns/100ps
`include "ipr_map.vh"

module ipr_prio_mem #(
  parameter WORDS = 14,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // Write port
  input  wire             we_i,
  input  wire [AW-1:0]    waddr_i,
  input  wire [15:0]      wdata_i,
  // Read port
  input  wire [AW-1:0]    raddr_i,
  output reg  [15:0]      rdata_o,
  // Flat view of all words
  output wire [WORDS*16-1:0] all_o
);

  reg [15:0] mem [0:WORDS-1];
  genvar g;

  // Storage words, top nibble bits masked off on write
  generate
    for (g = 0; g < WORDS; g = g + 1) begin : g_word
      always @(posedge clk_i) begin
        if (rst_i) begin
          mem[g] <= `IPR_RST_WORD;
        end else if (we_i && (waddr_i == g)) begin
          mem[g] <= wdata_i & `IPR_PRIO_MASK;
        end
      end
      assign all_o[g*16 +: 16] = mem[g];
    end
  endgenerate

  // Registered read; out of range reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (raddr_i < WORDS) begin
      rdata_o <= mem[raddr_i];
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule // ipr_prio_mem

// file: core/ipr_resolver.v
// Purpose: Interrupt priority resolver with Wishbone register access and reset cause logic
// Assumes: 50 MHz clk_i, synchronous active-high rst_i, request lines already on clk_i
// Notes:   Arbitration is one registered stage; reset causes drive a registered reset request held while any cause stands
//
// Function
// - Priority field is low three bits of each source nibble.
// - Nibble bit three ignores writes and reads zero.
// - Priority zero lowest, seven highest when comparing.
// - Natural order only breaks ties among equal pending priorities.
// - Natural order follows vector table; source 0 highest, 53 lowest.
// - Tie rank equals source number; lower number wins ties.
// - Vector number equals source number plus eight.
// - Sources 0-3, 5-14 assigned to listed peripherals.
// - Sources 16-22 and 27 assigned to listed peripherals.
// - Comparators 29-32, converter pairs 37-42; others reserved, never request.
// - Assigned priority dominates natural order.
// - Resolver takes no part in reset; program counter forced to zero. Here the resolver drives dev_reset_o from the error causes.
// - Execution starts at address zero, reached via jump stored there.
// - Four internal error conditions route to the reset vector.
// - Watchdog expiry resets the device.
// - Uninitialised working register used as pointer resets the device.
// - Executing an unused opcode resets the device.
// - Flushed illegal opcode does not raise the condition.
// - Simultaneous trap conditions cause lockout reset.
// - Priority zero means disabled, never presented.
// - Flags set regardless of enable; pending needs flag and enable.
// - Interrupt only when winner priority exceeds cpu priority level.
`timescale 1ns/100ps
`include "ipr_map.vh"

module ipr_resolver #(
  parameter NSRC = 54
) (
  // Clock and reset
  input  wire            clk_i,
  input  wire            rst_i,
  // Wishbone slave
  input  wire            cyc_i,
  input  wire            stb_i,
  input  wire            we_i,
  input  wire [7:0]      adr_i,
  input  wire [3:0]      sel_i,
  input  wire [31:0]     dat_i,
  output reg  [31:0]     dat_o,
  output reg             ack_o,
  // Peripheral event pulses, one per source
  input  wire [NSRC-1:0] event_i,
  // Core side
  input  wire [3:0]      cpu_priority_level_i,
  input  wire            int_ack_i,
  output reg             irq_valid_o,
  output reg  [5:0]      irq_src_o,
  output reg  [5:0]      irq_vec_o,
  output reg  [2:0]      irq_prio_o,
  // Error conditions from the core
  input  wire            wdt_expired_i,
  input  wire            uninit_w_ptr_i,
  input  wire            illegal_op_exec_i,
  input  wire            illegal_op_flushed_i,
  input  wire            trap_pending_i,
  input  wire [3:0]      trap_raise_i,
  // Reset request and reset vector
  output reg             dev_reset_o,
  output reg  [23:0]     reset_pc_o
);

  localparam AW = 4;

  // Bus state machine, one-hot
  localparam ST_IDLE = 2'b01;
  localparam ST_ACK  = 2'b10;

  reg  [1:0]       state;
  reg  [NSRC-1:0]  request_flag_regs;
  reg  [NSRC-1:0]  request_enable_regs;
  reg  [3:0]       cpu_pl_sw;
  reg  [4:0]       reset_cause;
  reg              rd_prio;
  reg  [31:0]      rd_mux;
  wire [15:0]      prio_rdata;
  wire [`IPR_PRIO_REGS*16-1:0] priority_config_regs;

  wire req      = cyc_i & stb_i;
  // In the ack cycle the master still holds its request; it must not be taken twice
  wire wr_go    = req & we_i & state[0] & ~ack_o;
  wire prio_hit = (adr_i >= `IPR_OFS_PRIO_BASE) &&
                  (adr_i < (`IPR_OFS_PRIO_BASE + 8'd4 * `IPR_PRIO_REGS));
  wire [7:0] prio_off = adr_i - `IPR_OFS_PRIO_BASE;
  wire [AW-1:0] prio_idx = prio_off[AW+1:2];

  // Priority field of source n, nibble bit three excluded
  function [2:0] src_prio;
    input [`IPR_PRIO_REGS*16-1:0] regs;
    input integer n;
    begin
      src_prio = regs[n*`IPR_NIB_W +: `IPR_PRIO_W];
    end
  endfunction

  // Merge a 16-bit slice of a write under byte lanes 0 and 1
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  sl;
    begin
      lane_merge = {sl[1] ? nw[15:8] : old[15:8], sl[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  ipr_prio_mem #(
    .WORDS (`IPR_PRIO_REGS),
    .AW    (AW)
  ) ipr_prio_mem_inst (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (wr_go & prio_hit & (|sel_i[1:0])),
    .waddr_i (prio_idx),
    .wdata_i (lane_merge(priority_config_regs[prio_idx*16 +: 16], dat_i[15:0], sel_i[1:0])),
    .raddr_i (prio_idx),
    .rdata_o (prio_rdata),
    .all_o   (priority_config_regs)
  );

  // Pending set: flagged, enabled, implemented, priority nonzero
  wire [NSRC-1:0] impl = `IPR_IMPL_MASK;
  reg  [NSRC-1:0] pend;
  integer k;
  always @* begin
    for (k = 0; k < NSRC; k = k + 1) begin
      pend[k] = request_flag_regs[k] & request_enable_regs[k] & impl[k]
                & (src_prio(priority_config_regs, k) != 3'd0);
    end
  end

  // Winner search: scan from highest number down so lower numbers override ties
  reg [2:0] best_p;
  reg [5:0] best_s;
  reg       best_v;
  integer j;
  always @* begin
    best_p = 3'd0;
    best_s = 6'd0;
    best_v = 1'b0;
    for (j = NSRC - 1; j >= 0; j = j - 1) begin
      if (pend[j] && (!best_v || src_prio(priority_config_regs, j) >= best_p)) begin
        best_p = src_prio(priority_config_regs, j);
        best_s = j[5:0];
        best_v = 1'b1;
      end
    end
  end

  // Core level: hardware input, or the software copy if it is higher
  wire [3:0] eff_pl = (cpu_priority_level_i > cpu_pl_sw) ? cpu_priority_level_i : cpu_pl_sw;

  // Registered winner every cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_valid_o <= 1'b0;
      irq_src_o   <= 6'd0;
      irq_vec_o   <= 6'd0;
      irq_prio_o  <= 3'd0;
    end else begin
      irq_valid_o <= best_v && ({1'b0, best_p} > eff_pl);
      irq_src_o   <= best_s;
      irq_vec_o   <= best_s + `IPR_VEC_BASE;
      irq_prio_o  <= best_p;
    end
  end

  // Flags: events set, software clears by writing ones; set wins
  wire [NSRC-1:0] wclr;
  wire [NSRC-1:0] wen_sel;
  wire [63:0] wfull = {dat_i[15:0], dat_i[15:0], dat_i[15:0], dat_i[15:0]};
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_bit
      localparam [7:0] FO = (g < 16) ? `IPR_OFS_FLAG0 : (g < 32) ? `IPR_OFS_FLAG1 : `IPR_OFS_FLAG2;
      localparam [7:0] EO = (g < 16) ? `IPR_OFS_ENA0 : (g < 32) ? `IPR_OFS_ENA1 : `IPR_OFS_ENA2;
      wire ln = sel_i[(g % 16) / 8];
      assign wclr[g]    = wr_go & ln & (adr_i == FO) & wfull[g];
      assign wen_sel[g] = wr_go & ln & (adr_i == EO);
      always @(posedge clk_i) begin
        if (rst_i) begin
          request_flag_regs[g]   <= 1'b0;
          request_enable_regs[g] <= 1'b0;
        end else begin
          if (event_i[g] & impl[g]) begin
            request_flag_regs[g] <= 1'b1;
          end else if (wclr[g] | (int_ack_i & (irq_src_o == g))) begin
            request_flag_regs[g] <= 1'b0;
          end
          if (wen_sel[g]) begin
            request_enable_regs[g] <= wfull[g];
          end
        end
      end
    end
  endgenerate

  // Error conditions that force a reset through the vector at zero
  wire lockout  = trap_pending_i | (trap_raise_i[0] + trap_raise_i[1] +
                  trap_raise_i[2] + trap_raise_i[3] > 3'd1);
  wire illegal  = illegal_op_exec_i & ~illegal_op_flushed_i;
  wire [4:0] cause_now = {1'b0, lockout & |trap_raise_i, illegal,
                          uninit_w_ptr_i, wdt_expired_i};
  // Software clear mask for the cause log, write one to clear
  wire [4:0] rc_clr = (wr_go && adr_i == `IPR_OFS_RSTCAUSE && sel_i[0]) ? dat_i[4:0] : 5'h00;

  // Reset request, cause log and program counter start address
  always @(posedge clk_i) begin
    if (rst_i) begin
      dev_reset_o <= 1'b0;
      reset_pc_o  <= `IPR_RST_PC;
      reset_cause <= 5'b1_0000;     // External reset seen
    end else begin
      dev_reset_o <= |cause_now;
      reset_pc_o  <= `IPR_RST_PC;
      reset_cause <= (reset_cause & ~rc_clr) | cause_now; // Set wins, bit by bit
    end
  end

  // Software copy of cpu priority level
  always @(posedge clk_i) begin
    if (rst_i) begin
      cpu_pl_sw <= 4'h0;
    end else if (wr_go && adr_i == `IPR_OFS_CPUPL && sel_i[0]) begin
      cpu_pl_sw <= dat_i[3:0];
    end
  end

  // Read mux for plain registers
  always @* begin
    case (adr_i)
      `IPR_OFS_FLAG0:    rd_mux = {16'h0000, request_flag_regs[15:0]};
      `IPR_OFS_FLAG1:    rd_mux = {16'h0000, request_flag_regs[31:16]};
      `IPR_OFS_FLAG2:    rd_mux = {10'h000, request_flag_regs[53:32]} & 32'h0000_FFFF;
      `IPR_OFS_ENA0:     rd_mux = {16'h0000, request_enable_regs[15:0]};
      `IPR_OFS_ENA1:     rd_mux = {16'h0000, request_enable_regs[31:16]};
      `IPR_OFS_ENA2:     rd_mux = {10'h000, request_enable_regs[53:32]} & 32'h0000_FFFF;
      `IPR_OFS_CPUPL:    rd_mux = {28'h000_0000, cpu_pl_sw};
      `IPR_OFS_WIN:      rd_mux = {16'h0000, irq_valid_o, irq_prio_o, irq_vec_o, irq_src_o};
      `IPR_OFS_RSTCAUSE: rd_mux = {27'h000_0000, reset_cause};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus handshake: ack two cycles after request, dropped the next cycle.
  // Priority words come from the memory's registered port, which is why ack waits a cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      state   <= ST_IDLE;
      ack_o   <= 1'b0;
      dat_o   <= 32'h0000_0000;
      rd_prio <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          ack_o <= 1'b0;
          if (req && !ack_o) begin
            state   <= ST_ACK;
            rd_prio <= prio_hit;
            dat_o   <= rd_mux;
          end
        end
        ST_ACK: begin
          ack_o <= 1'b1;
          if (rd_prio) begin
            dat_o <= {16'h0000, prio_rdata & `IPR_PRIO_MASK};
          end
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
          ack_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // ipr_resolver

// file: tb/ipr_core_model.sv
// Purpose: Core that takes a standing interrupt after a set delay
// Assumes: lat_i of zero means the core never takes
// Notes:   Keep lat_i at two or more so a cleared flag is not taken twice
`timescale 1ns/100ps
module ipr_core_model (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       irq_valid_i,
  input  wire [3:0] lat_i,
  output reg        int_ack_o = 1'b0
);
  reg [3:0] cnt = 4'h0;
  // Count a standing request, then answer with a one-cycle take
  always @(posedge clk_i) begin
    int_ack_o <= 1'b0;
    if (rst_i || !irq_valid_i || int_ack_o || lat_i == 4'h0)
      cnt <= 4'h0;
    else if (cnt == lat_i - 4'h1) begin
      int_ack_o <= 1'b1;
      cnt <= 4'h0;
    end else
      cnt <= cnt + 4'h1;
  end
endmodule // ipr_core_model

// file: tb/ipr_resolver_props.sv
// Purpose: Port-level checks of the priority resolver
// Assumes: Synchronous active-high rst_i on clk_i
// Notes:   Bound to every resolver instance
`timescale 1ns/100ps
`include "ipr_map.vh"
module ipr_resolver_props #(
  parameter NSRC = 54
) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        ack_o,
  input wire [3:0]  cpu_priority_level_i,
  input wire        irq_valid_o,
  input wire [5:0]  irq_src_o,
  input wire [5:0]  irq_vec_o,
  input wire [2:0]  irq_prio_o,
  input wire        wdt_expired_i,
  input wire        uninit_w_ptr_i,
  input wire        illegal_op_exec_i,
  input wire        illegal_op_flushed_i,
  input wire [3:0]  trap_raise_i,
  input wire        dev_reset_o,
  input wire [23:0] reset_pc_o
);
  localparam [63:0] IMPL = `IPR_IMPL_MASK;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // No watchdog, pointer or trap cause in this cycle
  sequence quiet;
    !wdt_expired_i && !uninit_w_ptr_i && trap_raise_i == 4'h0;
  endsequence
  // Acknowledge lasts one cycle only
  sequence ack_pulse;
    ack_o ##1 !ack_o;
  endsequence
  // Level compare uses the level the winner was registered against
  vec_map_a: assert property (irq_valid_o |-> irq_vec_o == irq_src_o + 6'h08)
    else $error("vector is not source plus eight");
  prio_live_a: assert property (irq_valid_o |-> irq_prio_o != 3'h0)
    else $error("priority zero source presented");
  level_gate_a: assert property (irq_valid_o && $stable(cpu_priority_level_i)
    |-> {1'b0, irq_prio_o} > $past(cpu_priority_level_i)) else $error("winner not above level");
  no_reserved_a: assert property (irq_valid_o |-> IMPL[irq_src_o])
    else $error("reserved source presented");
  pc_zero_a: assert property (reset_pc_o == 24'h00_0000)
    else $error("reset vector not zero");
  wdt_reset_a: assert property (wdt_expired_i |=> dev_reset_o)
    else $error("watchdog did not reset");
  uninit_reset_a: assert property (uninit_w_ptr_i |=> dev_reset_o)
    else $error("pointer fault did not reset");
  illegal_reset_a: assert property (illegal_op_exec_i && !illegal_op_flushed_i |=> dev_reset_o)
    else $error("illegal opcode did not reset");
  flush_quiet_a: assert property (illegal_op_flushed_i ##0 quiet |=> !dev_reset_o)
    else $error("flushed opcode caused reset");
  lockout_a: assert property ($countones(trap_raise_i) > 1 |=> dev_reset_o)
    else $error("trap lockout did not reset");
  ack_once_a: assert property ($rose(ack_o) |-> ack_pulse)
    else $error("ack longer than one cycle");
endmodule // ipr_resolver_props
bind ipr_resolver ipr_resolver_props #(.NSRC(NSRC)) ipr_resolver_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ack_o(ack_o), .cpu_priority_level_i(cpu_priority_level_i),
  .irq_valid_o(irq_valid_o), .irq_src_o(irq_src_o), .irq_vec_o(irq_vec_o),
  .irq_prio_o(irq_prio_o), .wdt_expired_i(wdt_expired_i), .uninit_w_ptr_i(uninit_w_ptr_i),
  .illegal_op_exec_i(illegal_op_exec_i), .illegal_op_flushed_i(illegal_op_flushed_i),
  .trap_raise_i(trap_raise_i), .dev_reset_o(dev_reset_o), .reset_pc_o(reset_pc_o));

// file: tb/tb_ipr_resolver.sv
// Purpose: Self-checking bench for the priority resolver
// Assumes: 50 MHz clock, two-edge Wishbone answer
// Notes:   Arbitration rows run from a fresh reset each
`timescale 1ns/100ps
`include "ipr_map.vh"
module tb_ipr_resolver;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0;
  reg         stb = 1'b0;
  reg         we = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] dat = 32'h0000_0000;
  reg  [53:0] ev = 54'h0;
  reg  [3:0]  lvl = 4'h0;
  reg  [3:0]  lat = 4'h0;
  reg  [4:0]  err = 5'h00;
  reg  [3:0]  trap = 4'h0;
  reg  [15:0] q;
  wire [31:0] dat_o;
  wire        ack_o;
  wire        int_ack;
  wire        irq_valid;
  wire        dev_reset;
  wire [5:0]  irq_src;
  wire [5:0]  irq_vec;
  wire [2:0]  irq_prio;
  wire [23:0] rpc;
  integer     failures = 0;
  integer     checked = 0;
  integer     r;
  // Source a, level a, source b, level b, expected winner
  int rows [0:6][0:4] = '{'{0,1,5,2,5}, '{5,4,2,4,2}, '{42,7,29,7,29}, '{9,0,14,1,14},
                         '{4,7,9,1,9}, '{53,7,27,3,27}, '{16,6,22,6,16}};
  always #10 clk_i = ~clk_i;
  ipr_resolver ipr_resolver_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'h3), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .event_i(ev), .cpu_priority_level_i(lvl), .int_ack_i(int_ack), .irq_valid_o(irq_valid),
    .irq_src_o(irq_src), .irq_vec_o(irq_vec), .irq_prio_o(irq_prio), .wdt_expired_i(err[0]),
    .uninit_w_ptr_i(err[1]), .illegal_op_exec_i(err[2]), .illegal_op_flushed_i(err[3]),
    .trap_pending_i(err[4]), .trap_raise_i(trap), .dev_reset_o(dev_reset), .reset_pc_o(rpc));
  ipr_core_model ipr_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .irq_valid_i(irq_valid),
    .lat_i(lat), .int_ack_o(int_ack));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Classic cycle: hold until ack is sampled, then one idle cycle
  task wb(input [7:0] a, input w, input [15:0] d);
    integer t;
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {16'h0000, d};
      t = 0;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && t < 20) begin
        @(posedge clk_i);
        t = t + 1;
      end
      if (t == 20)
        failures = failures + 1;
      q = dat_o[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  // Writes a level with the unused nibble bit set on purpose
  task pri(input int n, input int p);
    wb(8'h40 + 8'(4 * (n / 4)), 1'b1, 16'((p | 8) << (4 * (n % 4))));
  endtask
  task reboot;
    begin
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task report_and_stop;
    begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Hang guard, well beyond the few hundred cycles the run takes
  initial begin
    #200000;
    failures = failures + 1;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(`IPR_OFS_RSTCAUSE, 1'b0, 16'h0000);
    check(q, 32'h0000_0010);
    check(rpc, 32'h0000_0000);
    wb(8'h44, 1'b1, 16'hFFFF);
    wb(8'h44, 1'b0, 16'h0000);
    check(q, 32'h0000_7777);
    wb(8'h3C, 1'b0, 16'h0000);
    check(q, 32'h0000_0000);
    pri(3, 2);
    ev <= 54'h8;
    @(posedge clk_i);
    ev <= 54'h0;
    wb(`IPR_OFS_FLAG0, 1'b0, 16'h0000);
    check(q, 32'h0000_0008);
    check(irq_valid, 32'h0000_0000);
    wb(`IPR_OFS_ENA0, 1'b1, 16'h0008);
    repeat (2) @(posedge clk_i);
    check({irq_valid, irq_prio, irq_vec, irq_src}, {1'b1, 3'h2, 6'h0B, 6'h03});
    // Each cause alone; a flushed opcode, executed or not, must stay quiet
    for (r = 0; r < 5; r = r + 1) begin
      err <= (r == 4) ? 5'h0C : 5'h01 << r;
      @(posedge clk_i);
      err <= 5'h00;
      @(posedge clk_i);
      check(dev_reset, r < 3);
    end
    trap <= 4'h3;
    @(posedge clk_i);
    trap <= 4'h0;
    @(posedge clk_i);
    check(dev_reset, 32'h0000_0001);
    // Cause log holds external, watchdog, pointer, opcode and lockout; ones clear it
    wb(`IPR_OFS_RSTCAUSE, 1'b0, 16'h0000);
    check(q, 32'h0000_001F);
    wb(`IPR_OFS_RSTCAUSE, 1'b1, 16'h001F);
    wb(`IPR_OFS_RSTCAUSE, 1'b0, 16'h0000);
    check(q, 32'h0000_0000);
    // Writing a one clears the pending flag and withdraws the request
    wb(`IPR_OFS_FLAG0, 1'b1, 16'h0008);
    wb(`IPR_OFS_FLAG0, 1'b0, 16'h0000);
    check(q, 32'h0000_0000);
    check(irq_valid, 32'h0000_0000);
    for (r = 0; r < 7; r = r + 1) begin
      reboot;
      pri(rows[r][0], rows[r][1]);
      pri(rows[r][2], rows[r][3]);
      wb(`IPR_OFS_ENA0, 1'b1, 16'hFFFF);
      wb(`IPR_OFS_ENA1, 1'b1, 16'hFFFF);
      wb(`IPR_OFS_ENA2, 1'b1, 16'hFFFF);
      ev <= (54'h1 << rows[r][0]) | (54'h1 << rows[r][2]);
      @(posedge clk_i);
      ev <= 54'h0;
      repeat (3) @(posedge clk_i);
      check(irq_src, rows[r][4]);
      check(irq_vec, rows[r][4] + 8);
      check(irq_prio, rows[r][4] == rows[r][0] ? rows[r][1] : rows[r][3]);
    end
    // Equal level masks, one below lets it through
    lvl <= 4'h6;
    repeat (3) @(posedge clk_i);
    check(irq_valid, 32'h0000_0000);
    lvl <= 4'h5;
    repeat (3) @(posedge clk_i);
    check(irq_valid, 32'h0000_0001);
    // Software level equal to the winner masks it as well
    wb(`IPR_OFS_CPUPL, 1'b1, 16'h0006);
    repeat (2) @(posedge clk_i);
    check(irq_valid, 32'h0000_0000);
    wb(`IPR_OFS_CPUPL, 1'b1, 16'h0000);
    repeat (2) @(posedge clk_i);
    check(irq_valid, 32'h0000_0001);
    wb(`IPR_OFS_WIN, 1'b0, 16'h0000);
    check(q, {16'h0000, 1'b1, 3'h6, 6'h18, 6'h10});
    lat <= 4'h3;
    repeat (20) @(posedge clk_i);
    lat <= 4'h0;
    check(irq_valid, 32'h0000_0000);
    wb(`IPR_OFS_FLAG1, 1'b0, 16'h0000);
    check(q, 32'h0000_0000);
    report_and_stop;
  end
endmodule // tb_ipr_resolver
